// ===== scs_area_match.sv
// one chip-select area: fixed config word and upper-byte address match
// assumes the caller supplies the access address already stable
`timescale 1ns/1ps
module scs_area_match
    import scs_pkg::*;
#(
    parameter logic [7:0] START_BYTE = 8'h00
) (
    input wire logic [7:0] addr_top,
    output scs_area_cfg_t cfg,
    output logic [31:0] cfg_word,
    output logic hit
);
    // configuration is hard-wired, so writes can never alter it
    assign cfg.start_byte = START_BYTE;
    assign cfg.ale_used = SCS_ALE_USED_RST;
    assign cfg.read_burst_len = SCS_BURST_RST;
    assign cfg.area_bus_width = SCS_WIDTH_RST;

    // bits 23-16 read as the fill byte 0xFF; other unused bits read as zero
    assign cfg_word = (32'(cfg.start_byte) << SCS_START_LSB)
                    | (32'(SCS_FILL_BYTE) << SCS_FILL_LSB)
                    | (32'(cfg.ale_used) << SCS_ALE_BIT)
                    | (32'(cfg.read_burst_len) << SCS_BURST_LSB)
                    | (32'(cfg.area_bus_width) << SCS_WIDTH_LSB);

    assign hit = (addr_top == cfg.start_byte);
endmodule

// ===== scs_config.sv
// chip-select config registers, timing register and access sequencer
// assumes an axi4-lite master on aclk and one external access at a time
`timescale 1ns/1ps
// How it works
// - area two config returns start byte 0x62 in bits 31-24, writes ignored
// - area three config returns start byte 0x63 in bits 31-24, read-only
// - bit 11 tells whether address latch strobe is used; reads one
// - bits 5-3 give read burst: 000 one beat, 001 four beats; reads 000
// - bits 1-0 give area data width; 01 means 16 bits
// - timing register: write cycle bits 7-4, write pulse bits 13-11, in clocks
// - turnaround bits 19-17; bits 31-20 always zero
// - both areas serve 16-bit nor flash or sram on the muxed bus
// - read cycle codes 2..15, write cycle codes 3..15 clocks
// - turnaround, write pulse, oe delay codes 1..7 clocks
module scs_config
    import scs_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic mem_req,
    input wire logic mem_write,
    input wire logic [31:0] mem_addr,
    output logic mem_busy,
    output logic mem_done,
    output logic mem_miss,
    output logic [SCS_AREAS-1:0] area_sel,
    output logic ale_strobe,
    output logic [2:0] burst_len,
    output scs_timing_t timing
);
    generate
        if (ADDR_W < 4 || ADDR_W > 32) begin : g_bad_addr
            $error("scs_config: ADDR_W must be 4 to 32");
        end
    endgenerate

    localparam logic [7:0] AREA_START [SCS_AREAS] = '{SCS_AREA_TWO_START, SCS_AREA_THREE_START};

    // area decode and fixed config words
    scs_area_cfg_t area_cfg [SCS_AREAS];
    logic [31:0] area_word [SCS_AREAS];
    logic [SCS_AREAS-1:0] area_hit;
    genvar gi;
    generate
        for (gi = 0; gi < SCS_AREAS; gi++) begin : g_area
            scs_area_match #(.START_BYTE(AREA_START[gi])) u_match (
                .addr_top(mem_addr[31:24]),
                .cfg(area_cfg[gi]),
                .cfg_word(area_word[gi]),
                .hit(area_hit[gi])
            );
        end
    endgenerate

    // write channel holding registers
    logic aw_have_q, aw_have_d;
    logic w_have_q, w_have_d;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;
    logic [SCS_TIMING_W-1:0] timing_q;

    assign s_axi_awready = ce & ~aw_have_q & ~bvalid_q;
    assign s_axi_wready = ce & ~w_have_q & ~bvalid_q;
    assign s_axi_arready = ce & ~rvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;

    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take = s_axi_wvalid & s_axi_wready;
    wire ar_take = s_axi_arvalid & s_axi_arready;
    wire wr_commit = aw_have_q & w_have_q & ~bvalid_q;
    assign aw_have_d = (aw_have_q | aw_take) & ~wr_commit;
    assign w_have_d = (w_have_q | w_take) & ~wr_commit;

    wire [ADDR_W-1:0] wr_aligned = {awaddr_q[ADDR_W-1:2], 2'b00};
    wire wr_timing = (wr_aligned == ADDR_W'(SCS_OFF_TIMING));
    wire wr_ro = (wr_aligned == ADDR_W'(SCS_OFF_AREA_TWO))
               | (wr_aligned == ADDR_W'(SCS_OFF_AREA_THREE))
               | (wr_aligned == ADDR_W'(SCS_OFF_STATUS));
    wire [1:0] wr_resp = (wr_timing | wr_ro) ? SCS_RESP_OKAY : SCS_RESP_SLVERR;

    // byte-lane merge; only the low 20 bits are kept
    logic [31:0] merged;
    genvar bi;
    generate
        for (bi = 0; bi < 4; bi++) begin : g_lane
            assign merged[bi*8 +: 8] = wstrb_q[bi] ? wdata_q[bi*8 +: 8] : 8'(32'(timing_q) >> (bi*8));
        end
    endgenerate
    wire [SCS_TIMING_W-1:0] timing_d = (wr_commit & wr_timing) ? merged[SCS_TIMING_W-1:0] : timing_q;

    // sequencer state
    scs_state_t state_q, state_d;
    logic [3:0] cnt_q, cnt_d;
    logic [2:0] beats_q, beats_d;
    logic [SCS_AREAS-1:0] sel_q, sel_d;
    logic ale_q, ale_d;
    logic done_q, done_d;
    logic miss_q, miss_d;
    logic [2:0] burst_q, burst_d;
    logic [7:0] miss_cnt_q, miss_cnt_d;

    // read mux
    wire [ADDR_W-1:0] rd_aligned = {s_axi_araddr[ADDR_W-1:2], 2'b00};
    wire rd_a2 = (rd_aligned == ADDR_W'(SCS_OFF_AREA_TWO));
    wire rd_a3 = (rd_aligned == ADDR_W'(SCS_OFF_AREA_THREE));
    wire rd_tm = (rd_aligned == ADDR_W'(SCS_OFF_TIMING));
    wire rd_st = (rd_aligned == ADDR_W'(SCS_OFF_STATUS));
    wire [31:0] status_word = {16'h0000, miss_cnt_q, 3'b000, state_q, 1'b0, ~state_q[0]};
    wire [31:0] rd_word = rd_a2 ? area_word[0]
                        : rd_a3 ? area_word[1]
                        : rd_tm ? 32'(timing_q)
                        : rd_st ? status_word
                        : 32'h0000_0000;
    wire [1:0] rd_resp = (rd_a2 | rd_a3 | rd_tm | rd_st) ? SCS_RESP_OKAY : SCS_RESP_SLVERR;

    assign timing = scs_timing_t'(timing_q);

    // codes below the legal floor are treated as the floor
    wire [3:0] rc_eff = (timing.read_cycle_setting < SCS_RC_MIN) ? SCS_RC_MIN : timing.read_cycle_setting;
    wire [3:0] wc_eff = (timing.write_cycle_setting < SCS_WC_MIN) ? SCS_WC_MIN : timing.write_cycle_setting;
    wire [2:0] tr_eff = (timing.turnaround_setting < SCS_SHORT_MIN) ? SCS_SHORT_MIN
                      : timing.turnaround_setting;

    wire any_hit = |area_hit;
    wire [$clog2(SCS_AREAS)-1:0] hit_idx = area_hit[1] ? 1'b1 : 1'b0;
    wire [2:0] hit_burst = area_cfg[hit_idx].read_burst_len;
    wire [2:0] start_beats = (~mem_write && hit_burst == SCS_BURST_FOUR) ? SCS_FOUR_BEATS : 3'h1;
    wire [3:0] start_cnt = mem_write ? wc_eff - 4'h1 : rc_eff - 4'h1;
    wire [3:0] turn_cnt = {1'b0, tr_eff} - 4'h1;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        beats_d = beats_q;
        sel_d = sel_q;
        ale_d = 1'b0;
        done_d = 1'b0;
        miss_d = 1'b0;
        burst_d = burst_q;
        miss_cnt_d = miss_cnt_q;
        unique case (state_q)
            SCS_ST_IDLE: begin
                if (mem_req && any_hit) begin
                    sel_d = area_hit;
                    ale_d = area_cfg[hit_idx].ale_used;
                    burst_d = hit_burst;
                    beats_d = start_beats;
                    cnt_d = start_cnt;
                    state_d = SCS_ST_CYCLE;
                end else if (mem_req) begin
                    // outside every area: refused, counted, never strobed
                    miss_d = 1'b1;
                    miss_cnt_d = miss_cnt_q + 8'h01;
                end
            end
            SCS_ST_CYCLE: begin
                if (cnt_q != 4'h0) begin
                    cnt_d = cnt_q - 4'h1;
                end else if (beats_q != 3'h1) begin
                    beats_d = beats_q - 3'h1;
                    cnt_d = rc_eff - 4'h1;
                end else begin
                    done_d = 1'b1;
                    sel_d = '0;
                    cnt_d = turn_cnt;
                    state_d = SCS_ST_TURN;
                end
            end
            SCS_ST_TURN: begin
                if (cnt_q != 4'h0) begin
                    cnt_d = cnt_q - 4'h1;
                end else begin
                    state_d = SCS_ST_IDLE;
                end
            end
        endcase
    end

    assign mem_busy = ~state_q[0];
    assign mem_done = done_q;
    assign mem_miss = miss_q;
    assign area_sel = sel_q;
    assign ale_strobe = ale_q;
    assign burst_len = burst_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= SCS_RESP_OKAY;
            timing_q <= SCS_TIMING_RST;
        end else if (ce) begin
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            if (aw_take) begin
                awaddr_q <= s_axi_awaddr;
            end
            if (w_take) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_commit) begin
                bvalid_q <= 1'b1;
                bresp_q <= wr_resp;
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
            timing_q <= timing_d;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rresp_q <= SCS_RESP_OKAY;
            rdata_q <= 32'h0000_0000;
        end else if (ce) begin
            if (ar_take) begin
                rvalid_q <= 1'b1;
                rresp_q <= rd_resp;
                rdata_q <= rd_word;
            end else if (s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= SCS_ST_IDLE;
            cnt_q <= 4'h0;
            beats_q <= 3'h1;
            sel_q <= '0;
            ale_q <= 1'b0;
            done_q <= 1'b0;
            miss_q <= 1'b0;
            burst_q <= SCS_BURST_RST;
            miss_cnt_q <= 8'h00;
        end else if (ce) begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            beats_q <= beats_d;
            sel_q <= sel_d;
            ale_q <= ale_d;
            done_q <= done_d;
            miss_q <= miss_d;
            burst_q <= burst_d;
            miss_cnt_q <= miss_cnt_d;
        end
    end
endmodule

// ===== scs_config_asserts.sv
// timing and decode checks for the chip-select config block
// bound into scs_config; sees only its ports
`timescale 1ns/1ps
module scs_config_asserts
    import scs_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic mem_req,
    input wire logic mem_write,
    input wire logic [31:0] mem_addr,
    input wire logic mem_busy,
    input wire logic mem_done,
    input wire logic mem_miss,
    input wire logic [SCS_AREAS-1:0] area_sel,
    input wire logic ale_strobe,
    input wire logic [2:0] burst_len,
    input wire scs_timing_t timing
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic take, hit2, hit3, hit, ar_rd;
    logic [4:0] cnt_q, n_q, n_d;
    assign take = ce && mem_req && !mem_busy;
    assign hit2 = mem_addr[31:24] == SCS_AREA_TWO_START;
    assign hit3 = mem_addr[31:24] == SCS_AREA_THREE_START;
    assign hit = hit2 || hit3;
    assign ar_rd = s_axi_arvalid && s_axi_arready;
    // short codes clamp to the least legal count
    assign n_d = mem_write ? ((timing.write_cycle_setting < SCS_WC_MIN) ? 5'h3 : {1'b0, timing.write_cycle_setting})
                           : ((timing.read_cycle_setting < SCS_RC_MIN) ? 5'h2 : {1'b0, timing.read_cycle_setting});
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= 5'h0;
            n_q <= 5'h0;
        end else if (take && hit) begin
            // counts the busy cycles before the done pulse
            cnt_q <= 5'h0;
            n_q <= n_d;
        end else if (ce && mem_busy) begin
            cnt_q <= cnt_q + 5'h1;
        end
    end
    property p_sel_two; take && hit2 |=> area_sel == 2'h1 && mem_busy; endproperty
    a_sel_two: assert property (p_sel_two) else $error("area two select wrong");
    property p_sel_three; take && hit3 |=> area_sel == 2'h2 && mem_busy; endproperty
    a_sel_three: assert property (p_sel_three) else $error("area three select wrong");
    property p_miss; take && !hit |=> mem_miss && area_sel == 2'h0 && !mem_busy; endproperty
    a_miss: assert property (p_miss) else $error("miss not refused");
    property p_ale; take && hit |=> ale_strobe ##1 !ale_strobe; endproperty
    a_ale: assert property (p_ale) else $error("latch strobe wrong");
    property p_burst; burst_len == SCS_BURST_SINGLE; endproperty
    a_burst: assert property (p_burst) else $error("burst code wrong");
    property p_done_cnt; mem_done |-> cnt_q == n_q; endproperty
    a_done_cnt: assert property (p_done_cnt) else $error("cycle length wrong");
    // done is registered, so it lands one cycle after the last counted cycle
    property p_done_max; take && hit |-> ##[3:16] mem_done; endproperty
    a_done_max: assert property (p_done_max) else $error("access never done");
    property p_turn; mem_done |-> mem_busy && area_sel == 2'h0; endproperty
    a_turn: assert property (p_turn) else $error("turnaround missing");
    property p_rd_two; ar_rd && s_axi_araddr == SCS_OFF_AREA_TWO |=> s_axi_rvalid && s_axi_rdata == 32'h62FF0801; endproperty
    a_rd_two: assert property (p_rd_two) else $error("area two word wrong");
    property p_rd_three; ar_rd && s_axi_araddr == SCS_OFF_AREA_THREE |=> s_axi_rdata == 32'h63FF0801; endproperty
    a_rd_three: assert property (p_rd_three) else $error("area three word wrong");
    property p_rd_tim; ar_rd && s_axi_araddr == SCS_OFF_TIMING |=> s_axi_rdata[31:20] == 12'h000; endproperty
    a_rd_tim: assert property (p_rd_tim) else $error("timing upper bits set");
    c_read: cover property (take && hit2 && !mem_write);
    c_write: cover property (take && hit3 && mem_write);
    c_miss: cover property (mem_miss);
    c_long: cover property (mem_done && timing.turnaround_setting == 3'h7);
endmodule
bind scs_config scs_config_asserts #(.ADDR_W(ADDR_W)) u_chk (.aclk, .aresetn, .ce, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .mem_req, .mem_write, .mem_addr, .mem_busy, .mem_done,
    .mem_miss, .area_sel, .ale_strobe, .burst_len, .timing);

// ===== scs_mem_model.sv
// requester standing for the external memory side
// assumes the bench commands an access only while the block is idle
`timescale 1ns/1ps
module scs_mem_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic go,
    input wire logic go_write,
    input wire logic [31:0] go_addr,
    output logic mem_req,
    output logic mem_write,
    output logic [31:0] mem_addr
);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mem_req <= 1'b0;
            mem_write <= 1'b0;
            mem_addr <= 32'h0;
        end else if (go) begin
            // one-cycle request: a held level would be taken again after turnaround
            mem_req <= 1'b1;
            mem_write <= go_write;
            mem_addr <= go_addr; // 16-bit parts in both areas; misses only when commanded
        end else begin
            mem_req <= 1'b0;
            // released lines must not keep showing the last address
            mem_write <= ~mem_write;
            mem_addr <= ~mem_addr;
        end
    end
endmodule

// ===== scs_pkg.sv
// constants, field layouts and carrier types of the chip-select config block
// assumes a 32-bit register bus with one aligned word per register
package scs_pkg;
    // register byte offsets
    localparam logic [11:0] SCS_OFF_AREA_TWO = 12'h000;
    localparam logic [11:0] SCS_OFF_AREA_THREE = 12'h004;
    localparam logic [11:0] SCS_OFF_TIMING = 12'h008;
    localparam logic [11:0] SCS_OFF_STATUS = 12'h00C;

    // fixed per-area configuration content
    localparam int SCS_AREAS = 2;
    localparam logic [7:0] SCS_AREA_TWO_START = 8'h62;
    localparam logic [7:0] SCS_AREA_THREE_START = 8'h63;
    localparam logic [7:0] SCS_FILL_BYTE = 8'hFF;
    localparam logic SCS_ALE_USED_RST = 1'b1;
    localparam logic [2:0] SCS_BURST_SINGLE = 3'h0;
    localparam logic [2:0] SCS_BURST_FOUR = 3'h1;
    localparam logic [1:0] SCS_WIDTH_16 = 2'h1;
    localparam int SCS_START_LSB = 24;
    localparam int SCS_FILL_LSB = 16;
    localparam int SCS_ALE_BIT = 11;
    localparam int SCS_BURST_LSB = 3;
    localparam int SCS_WIDTH_LSB = 0;
    localparam logic [2:0] SCS_BURST_RST = SCS_BURST_SINGLE;
    localparam logic [1:0] SCS_WIDTH_RST = SCS_WIDTH_16;

    // timing register layout
    localparam int SCS_RC_LSB = 0;
    localparam int SCS_WC_LSB = 4;
    localparam int SCS_CEOE_LSB = 8;
    localparam int SCS_WP_LSB = 11;
    localparam int SCS_PC_LSB = 14;
    localparam int SCS_TR_LSB = 17;
    localparam int SCS_TIMING_W = 20;
    localparam logic [19:0] SCS_TIMING_RST = 20'h29144;

    // least legal codes of the timing fields other than page cycle
    localparam logic [3:0] SCS_RC_MIN = 4'h2;
    localparam logic [3:0] SCS_WC_MIN = 4'h3;
    localparam logic [2:0] SCS_SHORT_MIN = 3'h1;

    // beats of a four-beat read burst
    localparam logic [2:0] SCS_FOUR_BEATS = 3'h4;

    // axi responses
    localparam logic [1:0] SCS_RESP_OKAY = 2'h0;
    localparam logic [1:0] SCS_RESP_SLVERR = 2'h2;

    // field order matches bits 19 down to 0 of the timing register
    typedef struct packed {
        logic [2:0] turnaround_setting;
        logic [2:0] page_cycle_setting;
        logic [2:0] write_pulse_setting;
        logic [2:0] oe_delay_setting;
        logic [3:0] write_cycle_setting;
        logic [3:0] read_cycle_setting;
    } scs_timing_t;

    typedef struct packed {
        logic [7:0] start_byte;
        logic ale_used;
        logic [2:0] read_burst_len;
        logic [1:0] area_bus_width;
    } scs_area_cfg_t;

    typedef enum logic [2:0] {
        SCS_ST_IDLE = 3'b001,
        SCS_ST_CYCLE = 3'b010,
        SCS_ST_TURN = 3'b100
    } scs_state_t;
endpackage

// ===== tb_scs_config.sv
// bench for the chip-select config block: register reads and writes, external accesses
// assumes scs_config with its bound checker and the memory-side model
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin failures++; $display("mismatch %s exp %h got %h", n, e, g); end end
module tb_scs_config
    import scs_pkg::*;
;
    logic aclk, aresetn = 1'b0, ce = 1'b1, go = 1'b0, go_write = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [31:0] s_axi_wdata = 32'h0, go_addr = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, mem_req, mem_write;
    wire logic mem_busy, mem_done, mem_miss, ale_strobe;
    wire logic [1:0] s_axi_bresp, s_axi_rresp, area_sel;
    wire logic [2:0] burst_len;
    wire logic [31:0] s_axi_rdata, mem_addr;
    wire scs_timing_t timing;
    int failures = 0, tests_run = 0, i;
    logic [19:0] tv [8] = '{20'h29144, 20'h29144, 20'h00000, 20'h00000, 20'hE00CF, 20'hE00CF, 20'h29144, 20'h29144};
    logic [7:0] top [8] = '{8'h62, 8'h63, 8'h62, 8'h63, 8'h62, 8'h63, 8'h64, 8'h61};
    logic [1:0] as [8] = '{2'h1, 2'h2, 2'h1, 2'h2, 2'h1, 2'h2, 2'h0, 2'h0};
    logic [7:0] aw = 8'hAA;
    int an [8] = '{4, 4, 2, 3, 15, 12, 0, 0};
    int at [8] = '{1, 1, 1, 1, 7, 7, 0, 0};
    scs_config uut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mem_req, .mem_write, .mem_addr,
        .mem_busy, .mem_done, .mem_miss, .area_sel, .ale_strobe, .burst_len, .timing);
    scs_mem_model u_mem (.aclk, .aresetn, .go, .go_write, .go_addr, .mem_req, .mem_write, .mem_addr);
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    task end_sim;
        if (failures == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #100000;
        failures++;
        end_sim();
    end
    task axw(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        // no time limit here: the wait ends on bvalid, or else at the watchdog
        forever begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) break;
        end
        s_axi_bready <= 1'b0;
        `CHK("bresp", er, s_axi_bresp)
    endtask
    task axr(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) break;
        end
        s_axi_rready <= 1'b0;
        `CHK("rdata", ed, s_axi_rdata)
        `CHK("rresp", er, s_axi_rresp)
    endtask
    task acc(input logic w, input logic [31:0] a, input int n, input int t, input logic [1:0] sel);
        int c;
        @(posedge aclk);
        go <= 1'b1;
        go_write <= w;
        go_addr <= a;
        @(posedge aclk);
        go <= 1'b0;
        @(posedge aclk);
        #1;
        if (sel == 2'h0) begin
            `CHK("miss", 1'b1, mem_miss)
            `CHK("busy", 1'b0, mem_busy)
        end else begin
            `CHK("sel", sel, area_sel)
            `CHK("ale", 1'b1, ale_strobe)
            `CHK("burst", SCS_BURST_SINGLE, burst_len)
            // done is registered: it shows one cycle after the last access cycle
            c = 0;
            while (mem_done !== 1'b1 && c < 40) begin
                @(posedge aclk);
                #1;
                c++;
            end
            `CHK("cycles", n, c)
            // the done cycle is already the first turnaround cycle
            c = 0;
            while (mem_busy === 1'b1 && c < 40) begin
                c++;
                @(posedge aclk);
                #1;
            end
            `CHK("turn", t, c)
            `CHK("sel_off", 2'h0, area_sel)
        end
    endtask
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        axr(SCS_OFF_AREA_TWO, 32'h62FF0801, SCS_RESP_OKAY);
        axr(SCS_OFF_AREA_THREE, 32'h63FF0801, SCS_RESP_OKAY);
        axr(SCS_OFF_TIMING, 32'h00029144, SCS_RESP_OKAY);
        axr(SCS_OFF_STATUS, 32'h00000004, SCS_RESP_OKAY);
        axr(12'h010, 32'h0, SCS_RESP_SLVERR);
        axw(SCS_OFF_AREA_TWO, 32'hFFFFFFFF, 4'hF, SCS_RESP_OKAY);
        axw(SCS_OFF_AREA_THREE, 32'h0, 4'hF, SCS_RESP_OKAY);
        axw(12'h014, 32'h0, 4'hF, SCS_RESP_SLVERR);
        axr(SCS_OFF_AREA_TWO, 32'h62FF0801, SCS_RESP_OKAY);
        axr(SCS_OFF_AREA_THREE, 32'h63FF0801, SCS_RESP_OKAY);
        axw(SCS_OFF_TIMING, 32'hFFFFFFFF, 4'hF, SCS_RESP_OKAY);
        axr(SCS_OFF_TIMING, 32'h000FFFFF, SCS_RESP_OKAY);
        `CHK("timing", 20'hFFFFF, timing)
        axw(SCS_OFF_TIMING, 32'h00028B5C, 4'hF, SCS_RESP_OKAY);
        `CHK("wc", 4'h5, timing.write_cycle_setting)
        `CHK("wp", 3'h1, timing.write_pulse_setting)
        axw(SCS_OFF_TIMING, 32'hFFFFFFFF, 4'h2, SCS_RESP_OKAY);
        axr(SCS_OFF_TIMING, 32'h0002FF5C, SCS_RESP_OKAY);
        for (i = 0; i < 8; i++) begin
            axw(SCS_OFF_TIMING, {12'h0, tv[i]}, 4'hF, SCS_RESP_OKAY);
            acc(aw[i], {top[i], 24'h001234}, an[i], at[i], as[i]);
        end
        axr(SCS_OFF_STATUS, 32'h00000204, SCS_RESP_OKAY);
        @(posedge aclk);
        ce <= 1'b0;
        @(posedge aclk);
        #1;
        `CHK("arready", 1'b0, s_axi_arready)
        @(posedge aclk);
        ce <= 1'b1;
        end_sim();
    end
endmodule
